// File: core/fcps_top.sv
// APB register front end of the command parameter stage and its launch
// handshake toward the memory controller. Assumes a zero-wait APB master
// on clk and a controller on the same clock that drives one-cycle pulses.
// What this block does
// - Reserved factory-test register reads all zero and ignores writes.
// - Parameter array holds six 16-bit words as high and low bytes.
// - Every array byte register takes single-byte reads and writes.
// - Writing one to completion flag with both error flags clear launches command and clears flag.
// - Array is locked against software from launch until flag returns.
// - Controller results land in array, readable after completion.
// - Command code comes from high byte of word zero.
// - Address bits 23-16 from word0 low, 15-0 from word one.
// - Data words 0 to 3 come from array words two to five.
// - Words three and five sit at 0x12/0x13, 0x16/0x17, reset zero.
// - Version word in information row, version number in bits 3-0.
// - Version 0001 is first; 0000 and 1111 mean no version.
// - Mode input changes clock divider, config and protect writes.
// - Information row readable only while its window is active.
// - While flag is zero no new launch and no software array writes.
// - Launch hands array to controller; flag sets on completion.
`timescale 1ns/1ps
module fcps_top
	import fcps_pkg::*;
#(
	parameter logic [3:0] VERSION_NUM = VER_FIRST
)(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        special_mode_pin,
	input  wire logic        info_window_pin,
	output logic             ctl_launch,
	output logic      [7:0]  ctl_cmd_code,
	output logic      [23:0] ctl_global_addr,
	output logic      [63:0] ctl_data,
	output logic      [2:0]  ctl_word_count,
	input  wire logic        ctl_done,
	input  wire logic        ctl_result_we,
	input  wire logic [2:0]  ctl_result_idx,
	input  wire logic [15:0] ctl_result_word,
	input  wire logic        ctl_access_err,
	input  wire logic        ctl_prot_viol,
	output logic             cmd_complete,
	output logic             version_present
);

	// Elaboration guard on the version field
	generate
		if (VERSION_NUM == VER_NONE_LO || VERSION_NUM == VER_NONE_HI) begin
			$error("VERSION_NUM must encode a present version");
		end
	endgenerate

	// Reset release through two flops
	logic rst_s1_reg;
	logic rst_n_sync;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_reg <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_sync <= rst_s1_reg;
		end
	end

	// Pin synchronisers; first stage feeds only the second
	logic mode_s1_reg;
	logic mode_q_reg;
	logic win_s1_reg;
	logic win_q_reg;
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			mode_s1_reg <= 1'b0;
			mode_q_reg  <= 1'b0;
			win_s1_reg  <= 1'b0;
			win_q_reg   <= 1'b0;
		end else begin
			mode_s1_reg <= special_mode_pin;
			mode_q_reg  <= mode_s1_reg;
			win_s1_reg  <= info_window_pin;
			win_q_reg   <= win_s1_reg;
		end
	end

	// Array byte decode, shared by read and write paths
	function automatic logic arr_hit(input logic [5:0] idx);
		return (idx >= IDX_ARR_FIRST) && (idx <= IDX_ARR_LAST);
	endfunction
	function automatic logic [3:0] arr_byte(input logic [5:0] idx);
		logic [5:0] off;
		off = idx - IDX_ARR_FIRST;
		return off[3:0];
	endfunction

	// Bus phase and address decode
	wire [5:0] idx       = paddr[7:2];
	wire       setup     = psel && !penable;
	wire       access    = psel && penable;
	wire       wr_acc    = access && pwrite && pstrb[0];
	wire       hit_div   = (idx == IDX_CLK_DIV);
	wire       hit_index = (idx == IDX_PARAM_INDEX);
	wire       hit_cfg   = (idx == IDX_CONFIG);
	wire       hit_stat  = (idx == IDX_STATUS);
	wire       hit_eep   = (idx == IDX_EEP_PROTECT);
	wire       hit_rsvd  = (idx == IDX_RSVD_TEST);
	wire       hit_arr   = arr_hit(idx);
	wire       hit_info  = (idx == IDX_INFO_VER);
	wire       mapped    = hit_div || hit_index || hit_cfg || hit_stat ||
		hit_eep || hit_rsvd || hit_arr || hit_info;

	// Register state
	fcps_state_t state_reg;
	fcps_state_t state_next;
	logic       access_error_flag_reg;
	logic       pviol_reg;
	logic [7:0] div_reg;
	logic [7:0] cfg_reg;
	logic [7:0] eep_reg;
	logic [2:0] index_reg;
	logic       launch_reg;
	logic [31:0] prdata_reg;
	logic       pslverr_reg;
	wire        flag_set = (state_reg == ST_IDLE);
	wire [7:0]  arr_rd;
	wire [95:0] words;

	// Launch needs an idle flag and clear error flags
	wire wr_stat   = wr_acc && hit_stat;
	wire launch_rq = wr_stat && pwdata[ST_DONE_BIT] && flag_set &&
		!access_error_flag_reg && !pviol_reg;
	// Software array writes only while the flag reads one; results only while it reads zero
	wire arr_we    = wr_acc && hit_arr && flag_set;
	wire res_we    = ctl_result_we && !flag_set;

	// Flag state: launch clears, completion sets
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (launch_rq) begin
					state_next = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (ctl_done) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			state_reg  <= ST_IDLE;
			launch_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			launch_reg <= launch_rq;
		end
	end

	// Error flags: write one clears, a same-cycle event wins
	wire access_error_flag_next = ctl_access_err ||
		(access_error_flag_reg && !(wr_stat && pwdata[ST_ACCESS_ERROR_FLAG_BIT]));
	wire pviol_next  = ctl_prot_viol ||
		(pviol_reg && !(wr_stat && pwdata[ST_PVIOL_BIT]));
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			access_error_flag_reg <= 1'b0;
			pviol_reg  <= 1'b0;
		end else begin
			access_error_flag_reg <= access_error_flag_next;
			pviol_reg  <= pviol_next;
		end
	end

	// Mode-dependent writes: normal mode loads the divider once,
	// masks config, and only tightens protection
	wire       special  = mode_q_reg;
	wire       div_ok   = special || !div_reg[CLKDIV_LOADED_BIT];
	wire [7:0] div_next = {1'b1, pwdata[6:0]};
	wire [7:0] cfg_next = special ? pwdata[7:0] :
		((cfg_reg & ~CFG_NORMAL_MSK) | (pwdata[7:0] & CFG_NORMAL_MSK));
	wire       eep_open = eep_reg[EEP_OPEN_BIT] && pwdata[EEP_OPEN_BIT];
	wire [6:0] eep_size = (pwdata[6:0] > eep_reg[6:0]) ?
		pwdata[6:0] : eep_reg[6:0];
	wire [7:0] eep_next = special ? pwdata[7:0] : {eep_open, eep_size};

	// Control registers, all blocked while a command runs
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			div_reg   <= CLKDIV_RESET;
			cfg_reg   <= CONFIG_RESET;
			eep_reg   <= EEP_RESET;
			index_reg <= INDEX_RESET;
		end else if (wr_acc && flag_set) begin
			if (hit_div && div_ok) begin
				div_reg <= div_next;
			end
			if (hit_cfg) begin
				cfg_reg <= cfg_next;
			end
			if (hit_eep) begin
				eep_reg <= eep_next;
			end
			if (hit_index) begin
				index_reg <= pwdata[2:0];
			end
		end
	end

	// Parameter storage; byte-wide software port, word-wide results
	fcps_param_array fcps_param_array_inst (
		.clk         (clk),
		.rst_n       (rst_n_sync),
		.sw_we       (arr_we),
		.sw_byte_idx (arr_byte(idx)),
		.sw_wdata    (pwdata[7:0]),
		.ctl_we      (res_we),
		.ctl_word_idx(ctl_result_idx),
		.ctl_wdata   (ctl_result_word),
		.rd_byte_idx (arr_byte(idx)),
		.rd_data     (arr_rd),
		.words_flat  (words)
	);

	// Read mux; info row hidden while its window is inactive
	wire [15:0] info_word = {12'h000, VERSION_NUM};
	logic [31:0] rd_mux;
	always_comb begin
		if (hit_div) begin
			rd_mux = {24'h00_0000, div_reg};
		end else if (hit_index) begin
			rd_mux = {29'h0, index_reg};
		end else if (hit_cfg) begin
			rd_mux = {24'h00_0000, cfg_reg};
		end else if (hit_stat) begin
			rd_mux = {24'h00_0000, flag_set, 1'b0, access_error_flag_reg, pviol_reg,
				4'h0};
		end else if (hit_eep) begin
			rd_mux = {24'h00_0000, eep_reg};
		end else if (hit_rsvd) begin
			rd_mux = {24'h00_0000, RSVD_READ};
		end else if (hit_arr) begin
			rd_mux = {24'h00_0000, arr_rd};
		end else if (hit_info && win_q_reg) begin
			rd_mux = {16'h0000, info_word};
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	// Read data caught in the setup cycle, so it comes from a flop
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_reg <= !mapped;
		end
	end

	// Outputs; zero-wait slave
	assign pready          = 1'b1;
	assign prdata          = prdata_reg;
	assign pslverr         = pslverr_reg;
	assign cmd_complete    = flag_set;
	assign ctl_launch      = launch_reg;
	assign ctl_word_count  = index_reg;
	assign ctl_cmd_code    = words[95:88];
	assign ctl_global_addr = words[87:64];
	assign ctl_data        = words[63:0];
	assign version_present = (VERSION_NUM != VER_NONE_LO) &&
		(VERSION_NUM != VER_NONE_HI);

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_sync);

	rsvd_reads_zero_a: assert property (
		setup && !pwrite && hit_rsvd |=> prdata == 32'h0000_0000)
		else $error("reserved register read not zero");
	launch_clears_a: assert property (
		launch_rq |=> !cmd_complete && ctl_launch ##1 !ctl_launch)
		else $error("launch did not clear flag once");
	array_locked_a: assert property (
		!flag_set && !ctl_result_we |=> $stable(words))
		else $error("array changed while locked");
	done_sets_flag_a: assert property (
		!flag_set && ctl_done |=> cmd_complete)
		else $error("completion did not set flag");
	no_relaunch_a: assert property (
		!flag_set && !ctl_done |=> !ctl_launch)
		else $error("launch while busy");
	// Map checks skip a same-edge result write, which legally moves the byte
	cmd_code_map_a: assert property (
		setup && !pwrite && !res_we && idx == IDX_ARR_FIRST |=>
		prdata[7:0] == ctl_cmd_code)
		else $error("command code not from word zero high");
	w3_high_map_a: assert property (
		setup && !pwrite && !res_we && idx == IDX_W3_HIGH |=>
		prdata[7:0] == ctl_data[47:40])
		else $error("word three high misplaced");
	w5_low_map_a: assert property (
		setup && !pwrite && !res_we && idx == IDX_W5_LOW |=>
		prdata[7:0] == ctl_data[7:0])
		else $error("word five low misplaced");
	info_gated_a: assert property (
		setup && !pwrite && hit_info && !win_q_reg |=>
		prdata == 32'h0000_0000)
		else $error("info row visible outside window");
	err_set_wins_a: assert property (
		ctl_access_err |=> access_error_flag_reg ##1 (access_error_flag_reg || $past(wr_stat)))
		else $error("access error event lost");
	index_locked_a: assert property (
		!flag_set |=> $stable(ctl_word_count))
		else $error("index changed while busy");
	result_gated_a: assert property (
		flag_set && !arr_we |=> $stable(words))
		else $error("array changed while idle without a write");
	err_blocks_a: assert property (
		(access_error_flag_reg || pviol_reg) |=> !ctl_launch)
		else $error("launch with an error flag set");
	version_flag_a: assert property (
		version_present)
		else $error("version reported absent");
	info_visible_a: assert property (
		setup && !pwrite && hit_info && win_q_reg |=>
		prdata == {28'h000_0000, VERSION_NUM})
		else $error("version word not readable in window");
	addr_map_a: assert property (
		setup && !pwrite && !res_we &&
		idx == IDX_ARR_FIRST + 6'h01 |=>
		prdata[7:0] == ctl_global_addr[23:16])
		else $error("address high byte misplaced");
	data_map_a: assert property (
		setup && !pwrite && !res_we &&
		idx == IDX_ARR_FIRST + 6'h04 |=>
		prdata[7:0] == ctl_data[63:56])
		else $error("data word zero high misplaced");

endmodule

// File: core/fcps_pkg.sv
// Shared constants for the command parameter stage: register indices,
// status and control field positions, reset values and encodings.
// Assumes a 32-bit APB slave; byte address of a register is index * 4.
package fcps_pkg;

	// Register indices (byte address = index * 4)
	localparam int         IDX_W           = 6;
	localparam logic [5:0] IDX_CLK_DIV     = 6'h00;
	localparam logic [5:0] IDX_PARAM_INDEX = 6'h01;
	localparam logic [5:0] IDX_CONFIG      = 6'h04;
	localparam logic [5:0] IDX_STATUS      = 6'h06;
	localparam logic [5:0] IDX_EEP_PROTECT = 6'h09;
	localparam logic [5:0] IDX_RSVD_TEST   = 6'h0B;
	localparam logic [5:0] IDX_ARR_FIRST   = 6'h0C;
	localparam logic [5:0] IDX_ARR_LAST    = 6'h17;
	localparam logic [5:0] IDX_W3_HIGH     = 6'h12;
	localparam logic [5:0] IDX_W3_LOW      = 6'h13;
	localparam logic [5:0] IDX_W5_HIGH     = 6'h16;
	localparam logic [5:0] IDX_W5_LOW      = 6'h17;
	localparam logic [5:0] IDX_INFO_VER    = 6'h18;

	// Parameter array shape
	localparam int ARR_WORDS = 6;
	localparam int ARR_BYTES = 12;

	// Status and control fields
	localparam int ST_DONE_BIT       = 7;
	localparam int ST_ACCESS_ERROR_FLAG_BIT     = 5;
	localparam int ST_PVIOL_BIT      = 4;
	localparam int CLKDIV_LOADED_BIT = 7;
	localparam int EEP_OPEN_BIT      = 7;

	// Reset values and masks
	localparam logic [7:0] ARR_RESET      = 8'h00;
	localparam logic [7:0] RSVD_READ      = 8'h00;
	localparam logic [7:0] CLKDIV_RESET   = 8'h00;
	localparam logic [7:0] CONFIG_RESET   = 8'h00;
	localparam logic [7:0] CFG_NORMAL_MSK = 8'h0F;
	localparam logic [7:0] EEP_RESET      = 8'hFF;
	localparam logic [2:0] INDEX_RESET    = 3'h0;

	// Information row version word
	localparam logic [23:0] INFO_VER_ADDR = 24'h1F_C0B6;
	localparam logic [3:0]  VER_FIRST     = 4'h1;
	localparam logic [3:0]  VER_NONE_LO   = 4'h0;
	localparam logic [3:0]  VER_NONE_HI   = 4'hF;

	// Launch state; idle means the completion flag reads one
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} fcps_state_t;

endpackage

// File: core/fcps_param_array.sv
// Twelve-byte command parameter storage, six words of high and low byte.
// Assumes the caller gates writes; the controller port wins a collision.
`timescale 1ns/1ps
module fcps_param_array
	import fcps_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sw_we,
	input  wire logic [3:0]  sw_byte_idx,
	input  wire logic [7:0]  sw_wdata,
	input  wire logic        ctl_we,
	input  wire logic [2:0]  ctl_word_idx,
	input  wire logic [15:0] ctl_wdata,
	input  wire logic [3:0]  rd_byte_idx,
	output logic      [7:0]  rd_data,
	output logic      [95:0] words_flat
);

	logic [7:0] bytes_reg [ARR_BYTES];

	// Read port; out-of-range index reads zero
	assign rd_data = (rd_byte_idx < 4'(ARR_BYTES)) ?
		bytes_reg[rd_byte_idx] : 8'h00;

	// Each byte: controller result word, else software byte
	genvar g;
	generate
		for (g = 0; g < ARR_BYTES; g++) begin : g_byte
			localparam logic [2:0] WIDX = 3'(g / 2);
			localparam logic [3:0] BIDX = 4'(g);
			wire ctl_hit = ctl_we && (ctl_word_idx == WIDX);
			wire sw_hit  = sw_we && (sw_byte_idx == BIDX);
			wire [7:0] ctl_byte = (g % 2 == 0) ?
				ctl_wdata[15:8] : ctl_wdata[7:0];
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					bytes_reg[g] <= ARR_RESET;
				end else if (ctl_hit) begin
					bytes_reg[g] <= ctl_byte;
				end else if (sw_hit) begin
					bytes_reg[g] <= sw_wdata;
				end
			end
			// Word n occupies bits 95-16n .. 80-16n, high byte above
			assign words_flat[(ARR_BYTES-1-g)*8 +: 8] = bytes_reg[g];
		end
	endgenerate

endmodule

// File: testbench/fcps_top_tb.sv
// Self-checking bench for the command parameter stage: APB side and the
// controller side both driven here. Assumes zero-wait APB and one clock.
`timescale 1ns/1ps
module fcps_top_tb
	import fcps_pkg::*;
;
	localparam logic [7:0] A_CD = {IDX_CLK_DIV, 2'b00};
	localparam logic [7:0] A_IX = {IDX_PARAM_INDEX, 2'b00};
	localparam logic [7:0] A_CF = {IDX_CONFIG, 2'b00};
	localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
	localparam logic [7:0] A_PR = {IDX_EEP_PROTECT, 2'b00};
	localparam logic [7:0] A_RS = {IDX_RSVD_TEST, 2'b00};
	localparam logic [7:0] A_IN = {IDX_INFO_VER, 2'b00};
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        special_mode_pin = 1'b0;
	logic        info_window_pin = 1'b0;
	logic        ctl_launch;
	logic [7:0]  ctl_cmd_code;
	logic [23:0] ctl_global_addr;
	logic [63:0] ctl_data;
	logic [2:0]  ctl_word_count;
	logic        ctl_done = 1'b0;
	logic        ctl_result_we = 1'b0;
	logic [2:0]  ctl_result_idx = 3'h0;
	logic [15:0] ctl_result_word = 16'h0000;
	logic        ctl_access_err = 1'b0;
	logic        ctl_prot_viol = 1'b0;
	logic        cmd_complete;
	logic        version_present;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	logic [32:0] rdq[$];
	logic [99:0] lq[$];
	logic [7:0]  arr[12];
	logic [2:0]  cnt;
	logic [15:0] rw;
	// Everything the controller sees at launch, plus the flag level
	wire  [99:0] ln_got = {ctl_cmd_code, ctl_global_addr, ctl_data,
		ctl_word_count, cmd_complete};

	fcps_top fcps_top_inst (
		.clk             (clk),
		.resetn          (resetn),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.paddr           (paddr),
		.pwdata          (pwdata),
		.pstrb           (pstrb),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.special_mode_pin(special_mode_pin),
		.info_window_pin (info_window_pin),
		.ctl_launch      (ctl_launch),
		.ctl_cmd_code    (ctl_cmd_code),
		.ctl_global_addr (ctl_global_addr),
		.ctl_data        (ctl_data),
		.ctl_word_count  (ctl_word_count),
		.ctl_done        (ctl_done),
		.ctl_result_we   (ctl_result_we),
		.ctl_result_idx  (ctl_result_idx),
		.ctl_result_word (ctl_result_word),
		.ctl_access_err  (ctl_access_err),
		.ctl_prot_viol   (ctl_prot_viol),
		.cmd_complete    (cmd_complete),
		.version_present (version_present)
	);

	// 25 MHz clock
	always #20 clk = ~clk;

	task automatic bad(input string m);
		n_errors++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic results();
		if (n_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
		cmp_count++;
		if (g !== e)
			bad($sformatf("read %h want %h", g, e));
	endtask

	task automatic cmp_ln(input logic [99:0] e, input logic [99:0] g);
		cmp_count++;
		if (g !== e)
			bad($sformatf("launch %h want %h", g, e));
	endtask

	// One APB transfer; held until pready is seen at an access edge
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// Note the expected byte, then read
	task automatic rd(input logic [7:0] a, input logic [7:0] d);
		rdq.push_back({25'h000_0000, d});
		apb(1'b0, a, 32'h0000_0000);
	endtask

	function automatic logic [7:0] ab(input int i);
		return {IDX_ARR_FIRST + 6'(i), 2'b00};
	endfunction

	// Flag must read zero while the launch pulse stands
	function automatic logic [99:0] lexp(input logic [2:0] c);
		return {arr[0], arr[1], arr[2], arr[3], arr[4], arr[5], arr[6],
			arr[7], arr[8], arr[9], arr[10], arr[11], c, 1'b0};
	endfunction

	task automatic pulse_done();
		@(posedge clk);
		ctl_done <= 1'b1;
		@(posedge clk);
		ctl_done <= 1'b0;
	endtask

	// Watch completed reads and launches; oldest note is the reference
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (rdq.size() == 0)
				bad("unexpected read");
			else
				cmp_rd(rdq.pop_front(), {pslverr, prdata});
		end
		if (ctl_launch !== 1'b0) begin
			if (lq.size() == 0)
				bad("unexpected launch");
			else
				cmp_ln(lq.pop_front(), ln_got);
		end
	end

	// Cut a hang short; the run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad("timeout");
			results();
		end
	end

	initial begin
		void'($urandom(32'he97e_73e1));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		// Reset values, reserved place, unmapped index, lane strobe
		for (int i = 0; i < 12; i++)
			rd(ab(i), 8'h00);
		rd(A_ST, 8'h80);
		wr(A_RS, 32'h0000_00FF);
		rd(A_RS, 8'h00);
		rdq.push_back(33'h1_0000_0000);
		apb(1'b0, 8'h08, 32'h0000_0000);
		pstrb <= 4'h0;
		wr(A_IX, 32'h0000_0003);
		pstrb <= 4'hF;
		rd(A_IX, 8'h00);
		// Mode dependent registers, normal then special
		wr(A_CD, 32'h0000_0005);
		rd(A_CD, 8'h85);
		wr(A_CD, 32'h0000_000A);
		rd(A_CD, 8'h85);
		wr(A_CF, 32'h0000_00FF);
		rd(A_CF, 8'h0F);
		rd(A_PR, 8'hFF);
		wr(A_PR, 32'h0000_0005);
		rd(A_PR, 8'h7F);
		special_mode_pin <= 1'b1;
		repeat (3) @(posedge clk);
		wr(A_CD, 32'h0000_000A);
		rd(A_CD, 8'h8A);
		wr(A_CF, 32'h0000_00FF);
		rd(A_CF, 8'hFF);
		wr(A_PR, 32'h0000_0012);
		rd(A_PR, 8'h12);
		// Information row gated by its window
		rd(A_IN, 8'h00);
		info_window_pin <= 1'b1;
		repeat (3) @(posedge clk);
		rd(A_IN, {4'h0, VER_FIRST});
		cmp_rd(33'h1, {32'h0, version_present});
		// Random parameters; only the announced words are loaded
		cnt = 3'($urandom_range(5, 0));
		wr(A_IX, {29'h0, cnt});
		rd(A_IX, {5'h0, cnt});
		for (int i = 0; i < 12; i++) begin
			arr[i] = 8'h00;
			if (i < 2 * cnt + 2) begin
				arr[i] = 8'($urandom);
				wr(ab(i), {24'h0, arr[i]});
			end
		end
		for (int i = 0; i < 12; i++)
			rd(ab(i), arr[i]);
		lq.push_back(lexp(cnt));
		wr(A_ST, 32'h0000_0080);
		rd(A_ST, 8'h00);
		// Busy: array, index and relaunch writes all ignored
		wr(ab(0), {24'h0, ~arr[0]});
		wr(A_IX, 32'h0000_0007);
		wr(A_ST, 32'h0000_0080);
		rd(ab(0), arr[0]);
		rd(A_IX, {5'h0, cnt});
		// Controller returns a result word, then completes
		rw = 16'($urandom);
		@(posedge clk);
		ctl_result_we   <= 1'b1;
		ctl_result_idx  <= 3'h3;
		ctl_result_word <= rw;
		@(posedge clk);
		ctl_result_we <= 1'b0;
		pulse_done();
		arr[6] = rw[15:8];
		arr[7] = rw[7:0];
		rd(A_ST, 8'h80);
		rd(ab(6), arr[6]);
		rd(ab(7), arr[7]);
		// Error flags block a launch until cleared
		@(posedge clk);
		ctl_access_err <= 1'b1;
		ctl_prot_viol  <= 1'b1;
		@(posedge clk);
		ctl_access_err <= 1'b0;
		ctl_prot_viol  <= 1'b0;
		rd(A_ST, 8'hB0);
		wr(A_ST, 32'h0000_0080);
		rd(A_ST, 8'hB0);
		wr(A_ST, 32'h0000_0030);
		rd(A_ST, 8'h80);
		lq.push_back(lexp(cnt));
		wr(A_ST, 32'h0000_0080);
		pulse_done();
		rd(A_ST, 8'h80);
		// Reset in mid-run clears the array again
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ab(6), 8'h00);
		rd(ab(11), 8'h00);
		rd(A_ST, 8'h80);
		repeat (3) @(posedge clk);
		if (rdq.size() != 0 || lq.size() != 0)
			bad("notes left");
		results();
	end
endmodule
